// file: design/ipr_pkg.sv
// Shared constants for the interleaved pixel router block.
package ipr_pkg;
    // Register byte offsets.
    localparam logic [7:0] IPR_OFS_FORMAT = 8'h00;
    localparam logic [7:0] IPR_OFS_PTR    = 8'h04;
    localparam logic [7:0] IPR_OFS_DATA   = 8'h08;
    localparam logic [7:0] IPR_OFS_ROUTER = 8'h0c;
    localparam logic [7:0] IPR_OFS_STATUS = 8'h10;
    // Writable bits of the format, pointer and router registers, and their reset value; the others read as zero.
    localparam logic [31:0] IPR_FMT_WMASK = 32'h800f_fff1;
    localparam logic [31:0] IPR_PTR_WMASK = 32'h030f_000f;
    localparam logic [31:0] IPR_RTR_WMASK = 32'hffff_880f;
    localparam logic [31:0] IPR_REG_RST   = 32'h0000_0000;
    // Field positions.
    localparam int IPR_FMT_PACK_BIT  = 31;
    localparam int IPR_PTR_OFFS_LSB  = 0;
    localparam int IPR_PTR_INDEX_LSB = 16;
    localparam int IPR_PTR_TYPE_LSB  = 24;
    localparam int IPR_RTR_TAPS_LSB  = 0;
    localparam int IPR_RTR_WIDTH_BIT = 11;
    localparam int IPR_RTR_EN_BIT    = 15;
    localparam int IPR_RTR_MASK_LSB  = 16;
    localparam int IPR_STAT_OVF_BIT  = 0;
    localparam int IPR_STAT_BUSY_BIT = 1;
    localparam int IPR_STAT_LVL_LSB  = 8;
    // Table layout: the order table is type 0, one entry per slot.
    localparam int         IPR_TBL_AW      = 10;
    localparam logic [1:0] IPR_TBL_ORDER   = 2'h0;
    localparam logic [3:0] IPR_TBL_OFS0    = 4'h0;
    // Table-driven path line size limit in bytes.
    localparam logic [15:0] IPR_LINE_LIMIT = 16'h8000;
    localparam int          IPR_HTRANS_ACT = 1;
    typedef enum logic {IPR_ST_IDLE, IPR_ST_EMIT} ipr_state_type;
endpackage

// file: design/ipr_fifo.sv
// Synchronous valid/ready FIFO with parameterised width and depth.
`timescale 1ns/1ps
module ipr_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    // Refused at elaboration: the wrap-bit pointers need a power of two.
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("ipr_fifo: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr_reg;
    logic [AW:0]      rd_ptr_reg;

    // Full and empty come from pointers that carry one wrap bit.
    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;
    assign level     = wr_ptr_reg - rd_ptr_reg;
    assign in_ready  = (level != (AW + 1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data  = mem[rd_ptr_reg[AW-1:0]];

    // Storage has no reset; only the pointers define the contents.
    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    // Pointer update.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end
endmodule

// file: design/ipr_table_mem.sv
// Reformatter table store: one write port, two combinational read ports.
`timescale 1ns/1ps
module ipr_table_mem #(
    parameter int AW = 10,
    parameter int DW = 32
) (
    input  wire logic          hclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic [AW-1:0] raddr_a,
    output logic      [DW-1:0] rdata_a,
    input  wire logic [AW-1:0] raddr_b,
    output logic      [DW-1:0] rdata_b
);
    logic [DW-1:0] mem [1 << AW];

    // Asynchronous reads keep the pixel path free of table latency.
    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];

    // Software write port.
    always_ff @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end
endmodule

// file: design/ipr_top.sv
// Pixel path control: tap reformatter, interleave router, packing, FIFO.
//
// Notes on behaviour
// R1 - With packing set, every 10 to 16 bit pixel leaves as 16-bit word.
// R2 - Pointer selects offset, index and type; data register carries table word.
// R3 - Router interleaves the programmed tap count per incoming group; zero runs as one tap, counts above MAX_TAPS clamp.
// R4 - Pixel width bit: zero gives 8-bit pixels, one gives 10-16 bit.
// R5 - Router enable routes pixels through router instead of table reformatter.
// R6 - Router only interleaves taps in sequence, no other reordering.
// R7 - Software enables the router only for pixel-interleaved tap cameras.
// R8 - Table path caps each line at 32K bytes; router has no limit.
// R9 - Each set router mask bit forces that pixel bit to zero.
// R10 - Mask applies after interleave and before wide-pixel packing.
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ipr_top
    import ipr_pkg::*;
#(
    parameter int MAX_TAPS   = 10,
    parameter int TAP_W      = 16,
    parameter int FIFO_DEPTH = 32
) (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic [31:0]                    hrdata,
    input  wire logic                      tap_valid,
    output logic                           tap_ready,
    input  wire logic [MAX_TAPS*TAP_W-1:0] tap_data,
    input  wire logic                      tap_line_end,
    output logic                           pix_valid,
    input  wire logic                      pix_ready,
    output logic [15:0]                    pix_data,
    output logic                           pix_is16,
    output logic                           pix_line_end
);
    // Refused at elaboration: slot counter and tap select are 4 bits wide.
    if (MAX_TAPS < 1 || MAX_TAPS > 15 || TAP_W != 16) begin : g_bad_cfg
        $error("ipr_top: MAX_TAPS must be 1..15 and TAP_W 16");
    end
    localparam int          FW       = 18;
    localparam logic [3:0]  MAX_T4   = 4'(MAX_TAPS);

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave.
    logic [31:0]   fmt_reg;
    logic [31:0]   ptr_reg;
    logic [31:0]   rtr_reg;
    logic          ovf_reg;
    logic          dp_write_reg;
    logic          dp_read_reg;
    logic          rd_done_reg;
    logic [7:0]    dp_addr_reg;
    logic [31:0]   hrdata_reg;
    logic [31:0]   tbl_rdata_a;
    logic [31:0]   tbl_rdata_b;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;
    ipr_state_type state_reg;

    // Address phase is taken on an active transfer while the bus is ready.
    wire addr_take = hsel & hready & htrans[IPR_HTRANS_ACT];
    wire wr_en     = dp_write_reg;
    wire wr_fmt    = wr_en & (dp_addr_reg == IPR_OFS_FORMAT);
    wire wr_ptr    = wr_en & (dp_addr_reg == IPR_OFS_PTR);
    wire wr_dat    = wr_en & (dp_addr_reg == IPR_OFS_DATA);
    wire wr_rtr    = wr_en & (dp_addr_reg == IPR_OFS_ROUTER);
    wire wr_stat   = wr_en & (dp_addr_reg == IPR_OFS_STATUS);

    // Reads take one wait state so a read right after a write sees it.
    assign hreadyout = ~(dp_read_reg & ~rd_done_reg);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // Table address from the pointer fields: {type, index, offset}.
    wire [IPR_TBL_AW-1:0] tbl_waddr = {ptr_reg[IPR_PTR_TYPE_LSB +: 2],
                                       ptr_reg[IPR_PTR_INDEX_LSB +: 4],
                                       ptr_reg[IPR_PTR_OFFS_LSB +: 4]};

    // Status word; unmapped offsets read as zero.
    wire [31:0] stat_word = (32'(fifo_level) << IPR_STAT_LVL_LSB)
                          | (32'(state_reg == IPR_ST_EMIT)
                             << IPR_STAT_BUSY_BIT)
                          | (32'(ovf_reg) << IPR_STAT_OVF_BIT);
    wire [31:0] rd_mux =
        (dp_addr_reg == IPR_OFS_FORMAT) ? fmt_reg :
        (dp_addr_reg == IPR_OFS_PTR)    ? ptr_reg :
        (dp_addr_reg == IPR_OFS_DATA)   ? tbl_rdata_a :
        (dp_addr_reg == IPR_OFS_ROUTER) ? rtr_reg :
        (dp_addr_reg == IPR_OFS_STATUS) ? stat_word : 32'h0000_0000;

    // Data phase tracking.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write_reg <= 1'b0;
            dp_read_reg  <= 1'b0;
            rd_done_reg  <= 1'b0;
            dp_addr_reg  <= 8'h00;
        end else if (hreadyout) begin
            dp_write_reg <= addr_take & hwrite;
            dp_read_reg  <= addr_take & ~hwrite;
            rd_done_reg  <= 1'b0;
            dp_addr_reg  <= haddr[7:0];
        end else begin
            rd_done_reg  <= 1'b1;
        end
    end

    // Read data is latched during the wait state.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (dp_read_reg & ~rd_done_reg) begin
            hrdata_reg <= rd_mux;
        end
    end

    // Control registers; reserved fields are stored but steer nothing.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fmt_reg <= IPR_REG_RST;
            ptr_reg <= IPR_REG_RST;
            rtr_reg <= IPR_REG_RST;
        end else begin
            if (wr_fmt) fmt_reg <= hwdata & IPR_FMT_WMASK;
            if (wr_ptr) ptr_reg <= hwdata & IPR_PTR_WMASK; // R2
            if (wr_rtr) rtr_reg <= hwdata & IPR_RTR_WMASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel emitter.
    logic [TAP_W-1:0] hold_reg [MAX_TAPS];
    logic             line_end_reg;
    logic [3:0]       slot_reg;
    logic [15:0]      line_bytes_reg;
    logic             fifo_in_ready;

    wire        pack       = fmt_reg[IPR_FMT_PACK_BIT];
    wire        router_en  = rtr_reg[IPR_RTR_EN_BIT];
    wire        wide       = rtr_reg[IPR_RTR_WIDTH_BIT];
    wire [15:0] mask       = rtr_reg[IPR_RTR_MASK_LSB +: 16];
    wire [3:0]  taps_field = rtr_reg[IPR_RTR_TAPS_LSB +: 4];
    // A zero tap count is served as one tap; counts above MAX_TAPS clamp.
    wire [3:0]  taps_eff   = (taps_field == 4'h0) ? 4'h1 :
                             (taps_field > MAX_T4) ? MAX_T4 : taps_field;
    wire [3:0]  last_slot  = taps_eff - 4'h1;
    wire        last       = (slot_reg == last_slot); // R3
    // Router takes taps in order; table path reads the slot's source tap.
    wire [3:0]  tbl_src    = tbl_rdata_b[3:0];
    wire [3:0]  src_sel    = router_en ? slot_reg : tbl_src; // R5 R6
    wire [3:0]  src_tap    = (src_sel < MAX_T4) ? src_sel : 4'h0;
    wire [15:0] raw_pix    = hold_reg[src_tap];
    wire [15:0] masked     = router_en ? (raw_pix & ~mask) : raw_pix; // R9
    wire        is16       = wide & pack; // R1 R4
    // Mask first, then packing picks the word or its low byte.
    wire [15:0] emit_data  = is16 ? masked : {8'h00, masked[7:0]}; // R10
    wire [15:0] emit_bytes = is16 ? 16'h0002 : 16'h0001;
    wire [16:0] bytes_sum  = {1'b0, line_bytes_reg} + {1'b0, emit_bytes};
    // Only the table path counts bytes, so router lines are unbounded.
    wire        over       = ~router_en
                           & (bytes_sum > {1'b0, IPR_LINE_LIMIT}); // R8
    wire        emitting   = (state_reg == IPR_ST_EMIT);
    wire        advance    = emitting & (fifo_in_ready | over);
    wire        push       = emitting & fifo_in_ready & ~over;
    wire        line_done  = advance & last & line_end_reg;
    wire        ovf_set    = advance & over;
    wire        stat_clr   = wr_stat & hwdata[IPR_STAT_OVF_BIT];

    assign tap_ready = (state_reg == IPR_ST_IDLE);

    // Capture of one tap group, one holding word per tap.
    for (genvar g = 0; g < MAX_TAPS; g++) begin : g_hold
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                hold_reg[g] <= 16'h0000;
            end else if (tap_valid & tap_ready) begin
                hold_reg[g] <= tap_data[g*TAP_W +: TAP_W];
            end
        end
    end

    // Group sequencing: load, then one pixel per slot as the FIFO allows.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg    <= IPR_ST_IDLE;
            slot_reg     <= 4'h0;
            line_end_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                IPR_ST_IDLE: begin
                    if (tap_valid) begin
                        state_reg    <= IPR_ST_EMIT;
                        slot_reg     <= 4'h0;
                        line_end_reg <= tap_line_end;
                    end
                end
                IPR_ST_EMIT: begin
                    if (advance & last) begin
                        state_reg <= IPR_ST_IDLE;
                    end else if (advance) begin
                        slot_reg  <= slot_reg + 4'h1; // R6
                    end
                end
            endcase
        end
    end

    // Line byte count and the sticky overflow flag; a set beats a clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_bytes_reg <= 16'h0000;
            ovf_reg        <= 1'b0;
        end else begin
            if (line_done) begin
                line_bytes_reg <= 16'h0000;
            end else if (push & ~router_en) begin
                line_bytes_reg <= bytes_sum[15:0]; // R8
            end
            ovf_reg <= ovf_set | (ovf_reg & ~stat_clr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Table store and output FIFO.
    ipr_table_mem #(
        .AW (IPR_TBL_AW),
        .DW (32)
    ) u_table (
        .hclk    (hclk),
        .we      (wr_dat), // R2
        .waddr   (tbl_waddr),
        .wdata   (hwdata),
        .raddr_a (tbl_waddr),
        .rdata_a (tbl_rdata_a),
        .raddr_b ({IPR_TBL_ORDER, slot_reg, IPR_TBL_OFS0}),
        .rdata_b (tbl_rdata_b)
    );

    logic [FW-1:0] fifo_out;
    ipr_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (push),
        .in_ready  (fifo_in_ready),
        .in_data   ({is16, line_done, emit_data}),
        .out_valid (pix_valid),
        .out_ready (pix_ready),
        .out_data  (fifo_out),
        .level     (fifo_level)
    );
    assign pix_is16     = fifo_out[17];
    assign pix_line_end = fifo_out[16];
    assign pix_data     = fifo_out[15:0];

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    a_pack_wide_word: assert property ( // R1
        @(posedge hclk) disable iff (!hresetn)
        push && pack && wide |-> is16 && emit_data == masked)
        else $error("wide pixel not packed as a 16-bit word");
    a_table_readback: assert property ( // R2
        @(posedge hclk) disable iff (!hresetn)
        wr_dat |=> tbl_rdata_a == $past(hwdata))
        else $error("table word not stored at pointer");
    a_tap_count_done: assert property ( // R3
        @(posedge hclk) disable iff (!hresetn)
        advance && slot_reg == last_slot |=> state_reg == IPR_ST_IDLE)
        else $error("group did not end after tap count pixels");
    a_byte_pixel: assert property ( // R4
        @(posedge hclk) disable iff (!hresetn)
        push && !wide |-> !is16 && emit_data[15:8] == 8'h00)
        else $error("8-bit pixel carried upper bits");
    a_route_source: assert property ( // R5
        @(posedge hclk) disable iff (!hresetn)
        emitting && router_en && slot_reg < MAX_T4 |-> src_tap == slot_reg)
        else $error("router took a tap out of sequence");
    a_seq_order: assert property ( // R6
        @(posedge hclk) disable iff (!hresetn)
        advance && !last |=> slot_reg == $past(slot_reg) + 4'h1)
        else $error("router slot did not step by one");
    a_line_limit: assert property ( // R8
        @(posedge hclk) disable iff (!hresetn)
        advance |-> line_bytes_reg <= IPR_LINE_LIMIT && (push || !router_en))
        else $error("line size limit broken");
    a_mask_zero: assert property ( // R9
        @(posedge hclk) disable iff (!hresetn)
        push && router_en |-> (emit_data & mask) == 16'h0000)
        else $error("masked bit reached output");
    a_mask_then_pack: assert property ( // R10
        @(posedge hclk) disable iff (!hresetn)
        push && router_en && is16 |-> emit_data == (raw_pix & ~mask))
        else $error("mask not applied before packing");
endmodule

// file: test/ipr_camera_model.sv
// Camera-side model that offers pixel-interleaved tap groups.
`timescale 1ns/1ps
module ipr_camera_model #(
    parameter int MAX_TAPS = 10,
    parameter int TAP_W    = 16
) (
    input  wire logic                  hclk,
    input  wire logic                  tap_ready,
    output logic                       tap_valid,
    output logic [MAX_TAPS*TAP_W-1:0]  tap_data,
    output logic                       tap_line_end
);
    // The lines are idle and defined from time zero.
    initial begin
        tap_valid    = 1'b0;
        tap_data     = '0;
        tap_line_end = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Offer one group and hold it until it is taken; tap k carries the
    // k-th pixel of the interleave, never another tap geometry.
    task automatic send_group(input logic [MAX_TAPS*TAP_W-1:0] d,
                              input logic last);
        @(posedge hclk);
        tap_valid    <= 1'b1;
        tap_data     <= d;
        tap_line_end <= last;
        @(posedge hclk);
        while (tap_ready !== 1'b1) @(posedge hclk);
        // Released lines show the inverse so stale data cannot pass.
        tap_valid    <= 1'b0;
        tap_data     <= ~d;
        tap_line_end <= ~last;
    endtask
endmodule

// file: test/ipr_top_tb.sv
// Self-checking testbench for the pixel path with its register bus.
`timescale 1ns/1ps
module ipr_top_tb
    import ipr_pkg::*;
;
    logic         hclk      = 1'b0;
    logic         hresetn   = 1'b0;
    logic         hsel      = 1'b0;
    logic [31:0]  haddr     = 32'h0;
    logic [1:0]   htrans    = 2'h0;
    logic         hwrite    = 1'b0;
    logic [2:0]   hsize     = 3'h2;
    logic [31:0]  hwdata    = 32'h0;
    logic         pix_ready = 1'b1;
    wire          hreadyout;
    wire          hresp;
    wire  [31:0]  hrdata;
    wire          tap_valid;
    wire          tap_ready;
    wire  [159:0] tap_data;
    wire          tap_line_end;
    wire          pix_valid;
    wire  [15:0]  pix_data;
    wire          pix_is16;
    wire          pix_line_end;
    int           bad_count       = 0;
    int           samples_checked = 0;
    int           cyc             = 0;

    // The clock runs at 10 MHz.
    always #50 hclk = ~hclk;

    ipr_top #(.MAX_TAPS(10), .TAP_W(16), .FIFO_DEPTH(32)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .tap_valid(tap_valid), .tap_ready(tap_ready),
        .tap_data(tap_data), .tap_line_end(tap_line_end),
        .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
        .pix_is16(pix_is16), .pix_line_end(pix_line_end));

    ipr_camera_model #(.MAX_TAPS(10), .TAP_W(16)) cam (
        .hclk(hclk), .tap_ready(tap_ready), .tap_valid(tap_valid),
        .tap_data(tap_data), .tap_line_end(tap_line_end));

    ////////////////////////////////////////////////////////////////////////
    // A hang is cut short well beyond the longest expected run.
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 95000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Single word transfers; each phase is held until hready is seen.
    task automatic ahb_xfer(input logic wr, input logic [7:0] a,
                            input logic [31:0] d, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic ahb_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        ahb_xfer(1'b1, a, d, unused);
    endtask

    task automatic ahb_read(input logic [7:0] a, output logic [31:0] rd);
        ahb_xfer(1'b0, a, 32'h0, rd);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Tap k of group g holds a value distinct in both bytes.
    function automatic logic [15:0] pv(input int g, input int k);
        pv = 16'h9b00 ^ 16'(g * 16'h0421 + k * 16'h1013);
    endfunction

    function automatic logic [159:0] grp(input int g);
        for (int k = 0; k < 10; k++) grp[k*16 +: 16] = pv(g, k);
    endfunction

    // Waits for the next popped pixel, sampled away from the edge.
    task automatic exp_pix(input logic [15:0] d, input logic w,
                           input logic le);
        int n;
        n = 0;
        @(negedge hclk);
        while (!(pix_valid === 1'b1 && pix_ready === 1'b1) && n < 500) begin
            n++;
            @(negedge hclk);
        end
        // A pixel that never arrives is a failure, not a stale sample.
        if (n == 500) begin
            bad_count++;
        end
        chk("pix_data", {16'h0, pix_data}, {16'h0, d});
        chk("pix_is16", {31'h0, pix_is16}, {31'h0, w});
        chk("pix_line_end", {31'h0, pix_line_end}, {31'h0, le});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset values, write masks, an unmapped place and the order table.
    task automatic t_regs;
        logic [31:0] r;
        for (int i = 0; i < 5; i++) begin
            if (i != 2) begin
                ahb_read(8'(4 * i), r);
                chk("reset value", r, IPR_REG_RST);
            end
        end
        ahb_write(IPR_OFS_FORMAT, 32'hffff_ffff);
        ahb_write(IPR_OFS_PTR, 32'hffff_ffff);
        ahb_write(IPR_OFS_ROUTER, 32'hffff_ffff);
        ahb_write(IPR_OFS_DATA, 32'h5a3c_96e1);
        ahb_write(8'h20, 32'hffff_ffff);
        ahb_read(IPR_OFS_FORMAT, r);
        chk("format", r, IPR_FMT_WMASK);
        ahb_read(IPR_OFS_PTR, r);
        chk("pointer", r, IPR_PTR_WMASK);
        ahb_read(IPR_OFS_ROUTER, r);
        chk("router", r, IPR_RTR_WMASK);
        ahb_read(IPR_OFS_DATA, r);
        chk("table word", r, 32'h5a3c_96e1);
        ahb_read(8'h20, r);
        chk("unmapped", r, 32'h0);
        // Slot k takes tap 9-k, so a reversed order shows at the output.
        for (int k = 0; k < 10; k++) begin
            ahb_write(IPR_OFS_PTR, {6'h0, IPR_TBL_ORDER, 4'h0, 4'(k),
                                    12'h0, IPR_TBL_OFS0});
            ahb_write(IPR_OFS_DATA, 32'(9 - k));
            ahb_read(IPR_OFS_DATA, r);
            chk("order entry", r, 32'(9 - k));
        end
    endtask

    // Sends ng groups; with stall the sink holds off for 100 cycles, then checks that the FIFO is full.
    task automatic t_path(input logic en, input logic [3:0] taps,
                          input logic wide, input logic pack,
                          input logic [15:0] mask, input int ng,
                          input logic stall);
        int          n;
        logic [15:0] m;
        logic [31:0] r;
        n = (taps == 4'h0) ? 1 : int'(taps);
        ahb_write(IPR_OFS_FORMAT, {pack, 31'h0});
        ahb_write(IPR_OFS_ROUTER, {mask, en, 3'h0, wide, 7'h0, taps});
        pix_ready <= ~stall;
        fork
            for (int g = 0; g < ng; g++) cam.send_group(grp(g), g == ng - 1);
            begin
                if (stall) begin
                    repeat (100) @(posedge hclk);
                    ahb_read(IPR_OFS_STATUS, r);
                    chk("fifo full", r & 32'h3f02, 32'h2002);
                    pix_ready <= 1'b1;
                end
                for (int g = 0; g < ng; g++) begin
                    for (int k = 0; k < n; k++) begin
                        m = en ? pv(g, k) & ~mask : pv(g, 9 - k);
                        m = (wide & pack) ? m : {8'h0, m[7:0]};
                        exp_pix(m, wide & pack, g == ng - 1 && k == n - 1);
                    end
                end
            end
        join
    endtask

    // A line just over the table path's byte limit, in 8-bit pixels.
    task automatic t_long(input logic en, input logic ovf);
        logic [31:0] r;
        ahb_write(IPR_OFS_FORMAT, 32'h0);
        ahb_write(IPR_OFS_ROUTER, {16'h0, en, 11'h0, 4'ha});
        for (int g = 0; g < 3280; g++) cam.send_group(grp(g), g == 3279);
        repeat (20) @(posedge hclk);
        ahb_read(IPR_OFS_STATUS, r);
        chk("line overflow", {31'h0, r[0]}, {31'h0, ovf});
        ahb_write(IPR_OFS_STATUS, 32'h1);
        ahb_read(IPR_OFS_STATUS, r);
        chk("overflow clear", {31'h0, r[0]}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_path(1'b1, 4'h4, 1'b0, 1'b0, 16'h0000, 2, 1'b0);
        t_path(1'b1, 4'h3, 1'b1, 1'b1, 16'hfc00, 2, 1'b0);
        t_path(1'b1, 4'ha, 1'b1, 1'b0, 16'h00f0, 2, 1'b0);
        t_path(1'b1, 4'h0, 1'b0, 1'b1, 16'h0001, 2, 1'b0);
        t_path(1'b0, 4'h4, 1'b0, 1'b0, 16'hffff, 2, 1'b0);
        t_path(1'b1, 4'h4, 1'b0, 1'b0, 16'h0000, 10, 1'b1);
        t_long(1'b1, 1'b0);
        t_long(1'b0, 1'b1);
        tally_and_finish();
    end
endmodule
